// file: hw/gpd_port_map.svh
// Purpose: offsets, field positions, reset values and widths for the port block
// Assumes: 32-bit register bus with word-aligned byte addresses
// Notes:   data window fills the low 1 KB; control registers sit above it
`ifndef GPD_PORT_MAP_SVH
`define GPD_PORT_MAP_SVH

`define GPD_ADDR_W        12
`define GPD_MASK_HI       9
`define GPD_MASK_LO       2
`define GPD_DATA_TOP      12'h3FC
`define GPD_OFF_DIR       12'h400
`define GPD_OFF_AFSEL     12'h420
`define GPD_OFF_DR2       12'h500
`define GPD_OFF_DR4       12'h504
`define GPD_OFF_DR8       12'h508
`define GPD_OFF_ODEN      12'h50C
`define GPD_OFF_PUEN      12'h510
`define GPD_OFF_PDEN      12'h514
`define GPD_OFF_SLEW      12'h518
`define GPD_OFF_DEN       12'h51C
`define GPD_ZERO8         8'h00
`define GPD_ONES8         8'hFF
`define GPD_ZERO32        32'h0000_0000
`define GPD_DR2_RST       8'hFF
`define GPD_DBG_B_MASK    8'h80
`define GPD_DBG_C_MASK    8'h0F
`define GPD_PORT_B        3'h1
`define GPD_PORT_C        3'h2

`endif

// file: hw/gpd_pkg.sv
// Purpose: shared types for the port block
// Assumes: map header supplies the numbers
// Notes:   drive strength is a two-bit encoded choice per pin
package gpd_pkg;
   // drive strength choice for one pin
   typedef enum logic [1:0] {
      GPD_DRV_2MA = 2'b00,
      GPD_DRV_4MA = 2'b01,
      GPD_DRV_8MA = 2'b10
   } gpd_drive_t;
endpackage

// file: hw/gpd_pin_cell.sv
// Purpose: one pin's data capture and pad steering
// Assumes: inputs synchronous to CLK
// Notes:   one instance per pin
`timescale 1ns/1ps
`include "gpd_port_map.svh"
module gpd_pin_cell (
   input  wire logic clk,          // system clock
   input  wire logic rst_n,        // async reset, active low
   input  wire logic dir,          // 1 = output
   input  wire logic afsel,        // peripheral owns the pin
   input  wire logic wr_en,        // masked write hits this bit
   input  wire logic wr_val,       // value written
   input  wire logic pad_in,       // level on the pad
   input  wire logic alt_out,      // peripheral output value
   input  wire logic alt_oe,       // peripheral output enable
   input  wire logic od_en,        // open-drain mode
   output logic      data_q,       // stored data bit
   output logic      out_d,        // next pad output value
   output logic      oe_d          // next pad output enable
);
   // data bit: capture pad as input, hold written value as output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= 1'b0;
      end else if (!dir) begin
         data_q <= pad_in;
      end else if (wr_en) begin
         data_q <= wr_val;
      end
   end

   // pad steering, open drain only pulls low
   always_comb begin
      if (afsel) begin
         out_d = alt_out;
         oe_d  = alt_oe & ~(od_en & alt_out);
      end else begin
         out_d = data_q;
         oe_d  = dir & ~(od_en & data_q);
      end
   end
endmodule

// file: hw/gpd_port.sv
// Purpose: one general-purpose I/O port: direction, masked data, pad control
// Assumes: single clock; register bus never stalls; read data one cycle late
// Notes:   instantiate once per lettered port with PORT_ID set
// Summary of operation
// - eight port instances, one per letter, differing only in the debug pins of B and C
// - ordinary pins reset fully undriven
// - debug pins reset alt, digital, pull-up
// - any reset restores both default groups
// - direction zero: data captures pad value
// - direction one: data drives the pad
// - address bits nine to two mask data
// - data answers at all 256 words
// - masked write changes only selected bits
// - masked read returns zero elsewhere
// - pull-up, pull-down, open-drain, digital enable
// - per-pin 2, 4 or 8 mA drive
// - slew control only at 8 mA
// - alternate select hands pin to peripheral
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "gpd_port_map.svh"
module gpd_port #(
   parameter logic [2:0] PORT_ID = 3'h0,       // 0 = A ... 7 = H
   parameter int         PINS    = 8            // pins in this port
) (
   input  wire logic                   CLK,       // system clock, 10 MHz
   input  wire logic                   RSTN,      // power-on or pin reset
   input  wire logic [`GPD_ADDR_W-1:0] ADDR,      // byte address in port
   input  wire logic [31:0]            WDATA,     // write data
   input  wire logic                   WR,        // write strobe
   input  wire logic                   RD,        // read strobe
   output logic      [31:0]            RDATA,     // read data, one cycle late
   input  wire logic [PINS-1:0]        PAD_IN,    // pad input levels
   input  wire logic [PINS-1:0]        ALT_OUT,   // peripheral output values
   input  wire logic [PINS-1:0]        ALT_OE,    // peripheral output enables
   output logic      [PINS-1:0]        PAD_OUT,   // pad output value
   output logic      [PINS-1:0]        PAD_OE,    // pad output enable, high drives
   output logic      [PINS-1:0]        PAD_PU,    // weak pull-up
   output logic      [PINS-1:0]        PAD_PD,    // weak pull-down
   output logic      [PINS-1:0]        PAD_OD,    // open drain
   output logic      [PINS-1:0]        PAD_DEN,   // digital input enable
   output logic      [PINS-1:0]        PAD_DRV8,  // 8 mA drive
   output logic      [PINS-1:0]        PAD_DRV4,  // 4 mA drive
   output logic      [PINS-1:0]        PAD_SLEW,  // slew limit, 8 mA only
   output logic      [PINS-1:0]        PAD_ALT    // peripheral owns pin
);
   // register map, byte offsets inside the port:
   //    000-3FC  masked data window, mask from address 9:2
   //    400      direction, 1 drives the pin
   //    420      peripheral select
   //    500      2 mA select, set-only per bit
   //    504      4 mA select, set-only per bit
   //    508      8 mA select, set-only per bit
   //    50C      open-drain enables
   //    510      pull-up enables, clears pull-downs
   //    514      pull-down enables, clears pull-ups
   //    518      slew limit, honoured at 8 mA only
   //    51C      digital input enables
   //    other    writes dropped, reads zero
   // one block per port, debug pins here
   localparam logic [PINS-1:0] DBG_MASK =
      (PORT_ID == `GPD_PORT_B) ? PINS'(`GPD_DBG_B_MASK) :
      (PORT_ID == `GPD_PORT_C) ? PINS'(`GPD_DBG_C_MASK) : '0;

   // configuration registers
   logic [PINS-1:0] pin_direction_bits_q;   // 1 = output
   logic [PINS-1:0] alt_function_select_q;  // peripheral control
   logic [PINS-1:0] pull_up_enable_q;       // pull-up enables
   logic [PINS-1:0] pull_down_enable_q;     // pull-down enables
   logic [PINS-1:0] digital_pin_enable_q;   // digital enables
   logic [PINS-1:0] open_drain_q;           // open-drain enables
   logic [PINS-1:0] drv2_q;                 // 2 mA select
   logic [PINS-1:0] drv4_q;                 // 4 mA select
   logic [PINS-1:0] drv8_q;                 // 8 mA select
   logic [PINS-1:0] slew_q;                 // slew control
   // data path and bus helpers
   logic [PINS-1:0] masked_pin_data;        // stored data bits
   logic [PINS-1:0] out_d;                  // next pad value
   logic [PINS-1:0] oe_d;                   // next pad enable
   logic [PINS-1:0] addr_mask;              // per-pin address mask
   logic [PINS-1:0] wdata_pins;             // write data for the pins
   logic            data_hit;               // access in data window
   logic [31:0]     rdata_d;                // read mux result
   gpd_pkg::gpd_drive_t drive_sel [PINS];   // decoded strength per pin
   logic [PINS-1:0] drv8_sel;               // pins decoded to 8 mA
   logic [PINS-1:0] drv4_sel;               // pins decoded to 4 mA

   assign addr_mask  = PINS'(ADDR[`GPD_MASK_HI:`GPD_MASK_LO]);
   // low byte carries the pin values
   assign wdata_pins = WDATA[PINS-1:0];
   assign data_hit   = (ADDR <= `GPD_DATA_TOP);

   // direction register
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pin_direction_bits_q <= '0;
      // whole direction byte written
      end else if (WR && ADDR == `GPD_OFF_DIR) begin
         pin_direction_bits_q <= wdata_pins;
      end
   end

   // function and pull configuration with debug-pin defaults
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         alt_function_select_q <= DBG_MASK;
         digital_pin_enable_q  <= DBG_MASK;
         pull_up_enable_q      <= DBG_MASK;
         pull_down_enable_q    <= '0;
      // only bus writes change the configuration
      end else if (WR) begin
         // peripheral select byte
         if (ADDR == `GPD_OFF_AFSEL) begin
            alt_function_select_q <= wdata_pins;
         // digital input enables
         end else if (ADDR == `GPD_OFF_DEN) begin
            digital_pin_enable_q <= wdata_pins;
         end else if (ADDR == `GPD_OFF_PUEN) begin
            pull_up_enable_q   <= wdata_pins;
            pull_down_enable_q <= pull_down_enable_q & ~wdata_pins;
         end else if (ADDR == `GPD_OFF_PDEN) begin
            pull_down_enable_q <= wdata_pins;
            pull_up_enable_q   <= pull_up_enable_q & ~wdata_pins;
         end
      end
   end

   // drive strength: one-hot per pin, setting one clears the others
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         // every pin starts at 2 mA
         drv2_q <= PINS'(`GPD_DR2_RST);
         drv4_q <= '0;
         drv8_q <= '0;
      end else if (WR && ADDR == `GPD_OFF_DR2) begin
         drv2_q <= drv2_q | wdata_pins;
         drv4_q <= drv4_q & ~wdata_pins;
         drv8_q <= drv8_q & ~wdata_pins;
      // 4 mA select, clears the other two
      end else if (WR && ADDR == `GPD_OFF_DR4) begin
         drv4_q <= drv4_q | wdata_pins;
         drv2_q <= drv2_q & ~wdata_pins;
         drv8_q <= drv8_q & ~wdata_pins;
      // 8 mA select, clears the other two
      end else if (WR && ADDR == `GPD_OFF_DR8) begin
         drv8_q <= drv8_q | wdata_pins;
         drv2_q <= drv2_q & ~wdata_pins;
         drv4_q <= drv4_q & ~wdata_pins;
      end
   end

   // open drain and slew registers
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         // push-pull, no slew limit out of reset
         open_drain_q <= '0;
         slew_q       <= '0;
      end else if (WR && ADDR == `GPD_OFF_ODEN) begin
         open_drain_q <= wdata_pins;
      // slew limit bits
      end else if (WR && ADDR == `GPD_OFF_SLEW) begin
         slew_q <= wdata_pins;
      end
   end

   // decoded strength per pin, feeds the pad strength outputs
   always_comb begin
      drv8_sel = '0;
      drv4_sel = '0;
      for (int i = 0; i < PINS; i++) begin
         // 8 mA outranks the others
         if (drv8_q[i]) begin
            drive_sel[i] = gpd_pkg::GPD_DRV_8MA;
         // 4 mA next
         end else if (drv4_q[i]) begin
            drive_sel[i] = gpd_pkg::GPD_DRV_4MA;
         // neither set: 2 mA
         end else begin
            drive_sel[i] = gpd_pkg::GPD_DRV_2MA;
         end
         drv8_sel[i] = (drive_sel[i] == gpd_pkg::GPD_DRV_8MA);
         drv4_sel[i] = (drive_sel[i] == gpd_pkg::GPD_DRV_4MA);
      end
   end

   for (genvar g = 0; g < PINS; g++) begin : g_pin
      gpd_pin_cell u_cell (
         // shared clock and reset
         .clk     (CLK),
         .rst_n   (RSTN),
         .dir     (pin_direction_bits_q[g]),
         .afsel   (alt_function_select_q[g]),
         .wr_en   (WR & data_hit & addr_mask[g]),
         .wr_val  (wdata_pins[g]),
         .pad_in  (PAD_IN[g]),
         .alt_out (ALT_OUT[g]),
         .alt_oe  (ALT_OE[g]),
         .od_en   (open_drain_q[g]),
         // results back to the port
         .data_q  (masked_pin_data[g]),
         .out_d   (out_d[g]),
         .oe_d    (oe_d[g])
      );
   end

   // read mux, decode by address
   always_comb begin
      // unmapped addresses fall through as zero
      rdata_d = `GPD_ZERO32;
      if (data_hit) begin
         rdata_d[PINS-1:0] = masked_pin_data & addr_mask;
      // direction bits
      end else if (ADDR == `GPD_OFF_DIR) begin
         rdata_d[PINS-1:0] = pin_direction_bits_q;
      // peripheral select
      end else if (ADDR == `GPD_OFF_AFSEL) begin
         rdata_d[PINS-1:0] = alt_function_select_q;
      // 2 mA selects
      end else if (ADDR == `GPD_OFF_DR2) begin
         rdata_d[PINS-1:0] = drv2_q;
      // 4 mA selects
      end else if (ADDR == `GPD_OFF_DR4) begin
         rdata_d[PINS-1:0] = drv4_q;
      // 8 mA selects
      end else if (ADDR == `GPD_OFF_DR8) begin
         rdata_d[PINS-1:0] = drv8_q;
      // open-drain enables
      end else if (ADDR == `GPD_OFF_ODEN) begin
         rdata_d[PINS-1:0] = open_drain_q;
      // pull-up enables
      end else if (ADDR == `GPD_OFF_PUEN) begin
         rdata_d[PINS-1:0] = pull_up_enable_q;
      // pull-down enables
      end else if (ADDR == `GPD_OFF_PDEN) begin
         rdata_d[PINS-1:0] = pull_down_enable_q;
      // slew limit bits
      end else if (ADDR == `GPD_OFF_SLEW) begin
         rdata_d[PINS-1:0] = slew_q;
      // digital input enables
      end else if (ADDR == `GPD_OFF_DEN) begin
         rdata_d[PINS-1:0] = digital_pin_enable_q;
      end
   end

   // read data register, valid only the cycle after the strobe
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= `GPD_ZERO32;
      end else if (RD) begin
         RDATA <= rdata_d;
      // idle cycles read zero
      end else begin
         RDATA <= `GPD_ZERO32;
      end
   end

   // registered pad outputs
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PAD_OUT  <= '0;
         PAD_OE   <= '0;
         PAD_PU   <= DBG_MASK;
         PAD_PD   <= '0;
         PAD_OD   <= '0;
         PAD_DEN  <= DBG_MASK;
         PAD_DRV8 <= '0;
         PAD_DRV4 <= '0;
         PAD_SLEW <= '0;
         PAD_ALT  <= DBG_MASK;
      end else begin
         // pad drive from the pin cells
         PAD_OUT  <= out_d;
         PAD_OE   <= oe_d;
         // pull, open-drain, input enable, drive strength, slew and peripheral select levels
         PAD_PU   <= pull_up_enable_q;
         PAD_PD   <= pull_down_enable_q;
         PAD_OD   <= open_drain_q;
         PAD_DEN  <= digital_pin_enable_q;
         PAD_DRV8 <= drv8_sel;
         PAD_DRV4 <= drv4_sel;
         PAD_SLEW <= slew_q & drv8_sel;
         PAD_ALT  <= alt_function_select_q;
      end
   end
endmodule

// file: bench/gpd_port_monitor.sv
// Purpose: port-level checks on the port block
// Assumes: eight pins, one clock
// Notes:   bound into every port instance
`timescale 1ns/1ps
`include "gpd_port_map.svh"
module gpd_port_monitor #(
   parameter logic [2:0] PORT_ID = 3'h0,
   parameter int         PINS    = 8
) (
   input wire logic                   CLK,
   input wire logic                   RSTN,
   input wire logic [`GPD_ADDR_W-1:0] ADDR,
   input wire logic                   RD,
   input wire logic [31:0]            RDATA,
   input wire logic [PINS-1:0]        ALT_OUT,
   input wire logic [PINS-1:0]        PAD_OUT,
   input wire logic [PINS-1:0]        PAD_OE,
   input wire logic [PINS-1:0]        PAD_PU,
   input wire logic [PINS-1:0]        PAD_PD,
   input wire logic [PINS-1:0]        PAD_OD,
   input wire logic [PINS-1:0]        PAD_DEN,
   input wire logic [PINS-1:0]        PAD_DRV8,
   input wire logic [PINS-1:0]        PAD_DRV4,
   input wire logic [PINS-1:0]        PAD_SLEW,
   input wire logic [PINS-1:0]        PAD_ALT
);
   // debug pins that come up owned by the debug port
   localparam logic [7:0] DBG = (PORT_ID == `GPD_PORT_B) ? `GPD_DBG_B_MASK :
                                (PORT_ID == `GPD_PORT_C) ? `GPD_DBG_C_MASK : `GPD_ZERO8;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data outside its slot");
   AST_RD_MASK: assert property (RD && ADDR <= `GPD_DATA_TOP |=>
      (RDATA[7:0] & ~$past(ADDR[`GPD_MASK_HI:`GPD_MASK_LO])) == 8'h00) else $error("masked bit read nonzero");
   AST_RD_UPPER: assert property (RDATA[31:8] == 24'h00_0000)
      else $error("upper read bits nonzero");
   AST_RST_DEBUG: assert property ($rose(RSTN) |-> PAD_ALT == DBG && PAD_PU == DBG && PAD_DEN == DBG)
      else $error("debug pins not in debug state");
   AST_RST_IDLE: assert property ($rose(RSTN) |-> PAD_OE == 8'h00 && PAD_PD == 8'h00 && PAD_OD == 8'h00)
      else $error("ordinary pins not undriven");
   AST_DRV_ONE: assert property ((PAD_DRV8 & PAD_DRV4) == 8'h00)
      else $error("two drive strengths at once");
   AST_SLEW_8MA: assert property ((PAD_SLEW & ~PAD_DRV8) == 8'h00)
      else $error("slew limit without 8 mA");
   AST_PULL_EXCL: assert property ((PAD_PU & PAD_PD) == 8'h00)
      else $error("pull-up and pull-down together");
   AST_OD_LOW: assert property ((PAD_OD & PAD_OE & PAD_OUT) == 8'h00)
      else $error("open drain drives high");
   AST_ALT_OUT: assert property ($past(RSTN) && $stable(ALT_OUT) |-> ((PAD_OUT ^ ALT_OUT) & PAD_ALT) == 8'h00)
      else $error("peripheral pin not following peripheral");
endmodule
bind gpd_port gpd_port_monitor #(.PORT_ID(PORT_ID), .PINS(PINS)) mon (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
   .RD(RD), .RDATA(RDATA), .ALT_OUT(ALT_OUT), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_PU(PAD_PU),
   .PAD_PD(PAD_PD), .PAD_OD(PAD_OD), .PAD_DEN(PAD_DEN), .PAD_DRV8(PAD_DRV8), .PAD_DRV4(PAD_DRV4),
   .PAD_SLEW(PAD_SLEW), .PAD_ALT(PAD_ALT));

// file: bench/gpd_pad_model.sv
// Purpose: level seen on each package pad
// Assumes: external world drives ext_level when nothing else does
// Notes:   driver wins over pulls, pulls over outside level
`timescale 1ns/1ps
module gpd_pad_model (
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pad_pu,
   input  wire logic [7:0] pad_pd,
   input  wire logic [7:0] ext_level,
   output logic      [7:0] pad_in
);
   // resolve each pad
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i]) begin
            pad_in[i] = pad_out[i];
         end else if (pad_pu[i] | pad_pd[i]) begin
            pad_in[i] = pad_pu[i];
         end else begin
            pad_in[i] = ext_level[i];
         end
      end
   end
endmodule

// file: bench/gpd_port_test.sv
// Purpose: directed bench for one port instance set up as port B
// Assumes: read data stands one cycle after the strobe
// Notes:   pad outputs settle one cycle after a write lands
`timescale 1ns/1ps
`include "gpd_port_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module gpd_port_test;
   logic        CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0;
   logic [11:0] ADDR = 12'h000;
   logic [31:0] WDATA = 32'h0000_0000, RDATA;
   logic [7:0]  ALT_OUT = 8'h00, ALT_OE = 8'h00, EXT = 8'h35, PAD_IN;
   logic [7:0]  PAD_OUT, PAD_OE, PAD_PU, PAD_PD, PAD_OD, PAD_DEN, PAD_DRV8, PAD_DRV4, PAD_SLEW, PAD_ALT;
   int          n_mismatch = 0, num_checks = 0;
   gpd_port #(.PORT_ID(`GPD_PORT_B), .PINS(8)) uut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .PAD_IN(PAD_IN), .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .PAD_OUT(PAD_OUT),
      .PAD_OE(PAD_OE), .PAD_PU(PAD_PU), .PAD_PD(PAD_PD), .PAD_OD(PAD_OD), .PAD_DEN(PAD_DEN),
      .PAD_DRV8(PAD_DRV8), .PAD_DRV4(PAD_DRV4), .PAD_SLEW(PAD_SLEW), .PAD_ALT(PAD_ALT));
   gpd_pad_model pads (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .pad_pu(PAD_PU), .pad_pd(PAD_PD),
      .ext_level(EXT), .pad_in(PAD_IN));
   // 10 MHz clock
   always #50 CLK = ~CLK;
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= {24'h00_0000, d};
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      `CHK("read data", ex, RDATA)
   endtask
   task automatic settle;
      repeat (2) @(posedge CLK);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic t_defaults;
      settle;
      `CHK("pull-up", 8'h80, PAD_PU)
      `CHK("alt select", 8'h80, PAD_ALT)
      `CHK("digital enable", 8'h80, PAD_DEN)
      `CHK("pull-down", 8'h00, PAD_PD)
      `CHK("output enable", 8'h00, PAD_OE)
      rd(12'h3FC, 32'h0000_00B5);
   endtask
   task automatic t_masked;
      wr(`GPD_OFF_AFSEL, 8'h00);
      wr(`GPD_OFF_DIR, 8'hFF);
      wr(`GPD_DATA_TOP, 8'h00);
      wr(12'h098, 8'hEB);
      rd(`GPD_DATA_TOP, 32'h0000_0022);
      rd(12'h0C4, 32'h0000_0020);
      settle;
      `CHK("pad out", 8'h22, PAD_OUT)
      `CHK("output enable", 8'hFF, PAD_OE)
   endtask
   task automatic t_input;
      wr(`GPD_OFF_DIR, 8'h00);
      settle;
      rd(`GPD_DATA_TOP, 32'h0000_00B5);
      rd(12'h2A8, 32'h0000_00A0);
      wr(`GPD_DATA_TOP, 8'h00);
      rd(`GPD_DATA_TOP, 32'h0000_00B5);
   endtask
   task automatic t_pads;
      wr(`GPD_OFF_DR8, 8'h0F);
      wr(`GPD_OFF_DR4, 8'h03);
      wr(`GPD_OFF_DR2, 8'h04);
      wr(`GPD_OFF_SLEW, 8'hFF);
      wr(`GPD_OFF_PDEN, 8'hF0);
      wr(`GPD_OFF_PUEN, 8'h0F);
      wr(`GPD_OFF_DEN, 8'h55);
      settle;
      `CHK("drive 8", 8'h08, PAD_DRV8)
      `CHK("drive 4", 8'h03, PAD_DRV4)
      `CHK("slew", 8'h08, PAD_SLEW)
      rd(`GPD_OFF_DR2, 32'h0000_00F4);
      `CHK("pull-down", 8'hF0, PAD_PD)
      `CHK("pull-up", 8'h0F, PAD_PU)
      `CHK("digital enable", 8'h55, PAD_DEN)
   endtask
   task automatic t_alt_od;
      wr(`GPD_OFF_DIR, 8'hFF);
      wr(`GPD_DATA_TOP, 8'hFF);
      wr(`GPD_OFF_ODEN, 8'h0F);
      wr(`GPD_OFF_AFSEL, 8'h80);
      ALT_OUT <= 8'h7F;
      ALT_OE <= 8'h7F;
      settle;
      `CHK("open drain", 8'h0F, PAD_OD)
      `CHK("output enable", 8'h70, PAD_OE)
      `CHK("pad out", 8'h7F, PAD_OUT)
      rd(12'h004, 32'h0000_0001);
      wr(12'h600, 8'hFF);
      rd(12'h600, 32'h0000_0000);
   endtask
   // watchdog cuts a hang short
   initial begin
      repeat (3000) @(posedge CLK);
      n_mismatch++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge CLK);
      RSTN <= 1'b1;
      t_defaults;
      t_masked;
      t_input;
      t_pads;
      t_alt_od;
      @(posedge CLK);
      RSTN <= 1'b0;
      repeat (2) @(posedge CLK);
      RSTN <= 1'b1;
      t_defaults;
      complete_run;
   end
endmodule
